// *** apcc_top.sv ***
// analog power and clock control register with axi4-lite access and crystal kick generator
`include "apcc_defines.svh"
//
// Summary of operation
// - a one written to the measurement adc enable powers that adc up, with the bandgap already on.
// - sleep or current detection mode clears the measurement adc enable.
// - a one written to the current adc enable powers that adc up, with the bandgap already on.
// - sleep mode clears the current adc enable and current detection mode sets it.
// - with crystal kick enabled and the crystal stopped, a 1 ms pulse is sent once per second; enable resets low.
// - a one in the oscillator shutdown bit stops the crystal oscillator; reset leaves it running.
// - sleep and current detection modes both set the oscillator shutdown bit.
// - the two-bit adc clock select field picks the adc sample clock and resets to zero.
// - the register returns to defaults on power-on, receive-line or global software reset.
// - a one in the bandgap enable turns on the reference used by the adcs; it resets to zero.
module apcc_top #(
   parameter int unsigned KICK_WIDTH_CYC  = `APCC_KICK_WIDTH_CYC,
   parameter int unsigned KICK_PERIOD_CYC = `APCC_KICK_PERIOD_CYC
) (
   input  wire logic                      sys_clk_i,
   input  wire logic                      resetn_i,
   input  wire logic                      ce_i,
   input  wire logic                      soft_reset_i,
   input  wire logic                      sleep_mode_i,
   input  wire logic                      cur_detect_mode_i,
   input  wire logic                      crystal_stopped_i,
   output apcc_pkg::apcc_ctrl_t           ctrl_o,
   output logic                           crystal_kick_o,
   input  wire logic [`APCC_AXI_AW-1:0]   s_axi_awaddr_i,
   input  wire logic                      s_axi_awvalid_i,
   output logic                           s_axi_awready_o,
   input  wire logic [31:0]               s_axi_wdata_i,
   input  wire logic [3:0]                s_axi_wstrb_i,
   input  wire logic                      s_axi_wvalid_i,
   output logic                           s_axi_wready_o,
   output logic [1:0]                     s_axi_bresp_o,
   output logic                           s_axi_bvalid_o,
   input  wire logic                      s_axi_bready_i,
   input  wire logic [`APCC_AXI_AW-1:0]   s_axi_araddr_i,
   input  wire logic                      s_axi_arvalid_i,
   output logic                           s_axi_arready_o,
   output logic [31:0]                    s_axi_rdata_o,
   output logic [1:0]                     s_axi_rresp_o,
   output logic                           s_axi_rvalid_o,
   input  wire logic                      s_axi_rready_i
);

   function automatic logic [31:0] apcc_to_word(input apcc_pkg::apcc_ctrl_t c);
      logic [31:0] w;
      w                                         = 32'h0000_0000;
      w[`APCC_BIT_BANDGAP]                      = c.bandgap_enable;
      w[`APCC_BIT_MEAS_ADC]                     = c.meas_adc_enable;
      w[`APCC_BIT_CUR_ADC]                      = c.cur_adc_enable;
      w[`APCC_BIT_RSVD_HI:`APCC_BIT_RSVD_LO]    = c.reserved;
      w[`APCC_BIT_KICK]                         = c.crystal_kick_enable;
      w[`APCC_BIT_OSC_PD]                       = c.crystal_osc_shutdown;
      w[`APCC_BIT_DIV_BYP]                      = c.crystal_divider_bypass;
      w[`APCC_BIT_LOW_DRV]                      = c.crystal_low_drive;
      w[`APCC_BIT_CSEL_HI:`APCC_BIT_CSEL_LO]    = c.adc_clock_select;
      return w;
   endfunction : apcc_to_word

   function automatic apcc_pkg::apcc_ctrl_t apcc_from_word(input logic [31:0] w);
      apcc_pkg::apcc_ctrl_t c;
      c.bandgap_enable         = w[`APCC_BIT_BANDGAP];
      c.meas_adc_enable        = w[`APCC_BIT_MEAS_ADC];
      c.cur_adc_enable         = w[`APCC_BIT_CUR_ADC];
      c.reserved               = w[`APCC_BIT_RSVD_HI:`APCC_BIT_RSVD_LO];
      c.crystal_kick_enable    = w[`APCC_BIT_KICK];
      c.crystal_osc_shutdown   = w[`APCC_BIT_OSC_PD];
      c.crystal_divider_bypass = w[`APCC_BIT_DIV_BYP];
      c.crystal_low_drive      = w[`APCC_BIT_LOW_DRV];
      c.adc_clock_select       = w[`APCC_BIT_CSEL_HI:`APCC_BIT_CSEL_LO];
      return c;
   endfunction : apcc_from_word

   // crystal stopped synchroniser
   logic stop_meta_r;
   logic stop_sync_r;
   logic stop_meta_nxt;
   logic stop_sync_nxt;

   always_comb begin
      stop_meta_nxt = crystal_stopped_i;
      stop_sync_nxt = stop_meta_r;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         stop_meta_r <= 1'b0;
         stop_sync_r <= 1'b0;
      end else if (ce_i) begin
         stop_meta_r <= stop_meta_nxt;
         stop_sync_r <= stop_sync_nxt;
      end
   end

   // axi4-lite write channel
   logic                    aw_hold_r;
   logic                    aw_hold_nxt;
   logic [`APCC_AXI_AW-1:0] aw_addr_r;
   logic [`APCC_AXI_AW-1:0] aw_addr_nxt;
   logic                    w_hold_r;
   logic                    w_hold_nxt;
   logic [31:0]             w_data_r;
   logic [31:0]             w_data_nxt;
   logic [3:0]              w_strb_r;
   logic [3:0]              w_strb_nxt;
   logic                    awready_nxt;
   logic                    wready_nxt;
   logic                    bvalid_nxt;
   logic [1:0]              bresp_nxt;
   logic                    wr_go;
   logic                    wr_hit;

   // address and data are latched independently so either may come first
   always_comb begin
      wr_go       = aw_hold_r && w_hold_r && !s_axi_bvalid_o;
      wr_hit      = (aw_addr_r == `APCC_CTRL0_ADDR);
      aw_hold_nxt = aw_hold_r ? !wr_go : (s_axi_awvalid_i && s_axi_awready_o);
      aw_addr_nxt = (s_axi_awvalid_i && s_axi_awready_o) ? s_axi_awaddr_i : aw_addr_r;
      w_hold_nxt  = w_hold_r ? !wr_go : (s_axi_wvalid_i && s_axi_wready_o);
      w_data_nxt  = (s_axi_wvalid_i && s_axi_wready_o) ? s_axi_wdata_i : w_data_r;
      w_strb_nxt  = (s_axi_wvalid_i && s_axi_wready_o) ? s_axi_wstrb_i : w_strb_r;
      awready_nxt = !aw_hold_nxt;
      wready_nxt  = !w_hold_nxt;
      bvalid_nxt  = s_axi_bvalid_o ? !s_axi_bready_i : wr_go;
      bresp_nxt   = wr_go ? (wr_hit ? `APCC_RESP_OKAY : `APCC_RESP_SLVERR) : s_axi_bresp_o;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         aw_hold_r       <= 1'b0;
         aw_addr_r       <= '0;
         w_hold_r        <= 1'b0;
         w_data_r        <= 32'h0000_0000;
         w_strb_r        <= 4'h0;
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o  <= 1'b1;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= `APCC_RESP_OKAY;
      end else if (ce_i) begin
         aw_hold_r       <= aw_hold_nxt;
         aw_addr_r       <= aw_addr_nxt;
         w_hold_r        <= w_hold_nxt;
         w_data_r        <= w_data_nxt;
         w_strb_r        <= w_strb_nxt;
         s_axi_awready_o <= awready_nxt;
         s_axi_wready_o  <= wready_nxt;
         s_axi_bvalid_o  <= bvalid_nxt;
         s_axi_bresp_o   <= bresp_nxt;
      end
   end

   // control word
   apcc_pkg::apcc_ctrl_t ctrl_nxt;
   logic [31:0]          word_cur;
   logic [31:0]          word_new;

   always_comb begin
      word_cur = apcc_to_word(ctrl_o);
      word_new = word_cur;
      for (int b = 0; b < 4; b++) begin
         if (w_strb_r[b]) begin
            word_new[8*b +: 8] = w_data_r[8*b +: 8];
         end
      end
      if (soft_reset_i) begin
         ctrl_nxt = apcc_from_word(`APCC_CTRL0_RESET);
      end else if (wr_go && wr_hit) begin
         ctrl_nxt = apcc_from_word(word_new);
      end else begin
         ctrl_nxt = ctrl_o;
      end
      // forcing sits after the write so a mode always wins; the forced values remain once the mode ends
      if (sleep_mode_i) begin
         ctrl_nxt.bandgap_enable       = 1'b0;
         ctrl_nxt.meas_adc_enable      = 1'b0;
         ctrl_nxt.cur_adc_enable       = 1'b0;
         ctrl_nxt.crystal_osc_shutdown = 1'b1;
      end else if (cur_detect_mode_i) begin
         ctrl_nxt.bandgap_enable       = 1'b1;
         ctrl_nxt.meas_adc_enable      = 1'b0;
         ctrl_nxt.cur_adc_enable       = 1'b1;
         ctrl_nxt.crystal_osc_shutdown = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ctrl_o <= apcc_from_word(`APCC_CTRL0_RESET);
      end else if (ce_i) begin
         ctrl_o <= ctrl_nxt;
      end
   end

   // axi4-lite read channel
   logic        arready_nxt;
   logic        rvalid_nxt;
   logic [31:0] rdata_nxt;
   logic [1:0]  rresp_nxt;
   logic        rd_go;

   // readback shows the live control state including any forced bits
   always_comb begin
      rd_go       = s_axi_arvalid_i && s_axi_arready_o;
      rvalid_nxt  = s_axi_rvalid_o ? !s_axi_rready_i : rd_go;
      arready_nxt = !rvalid_nxt;
      rdata_nxt   = s_axi_rdata_o;
      rresp_nxt   = s_axi_rresp_o;
      if (rd_go) begin
         if (s_axi_araddr_i == `APCC_CTRL0_ADDR) begin
            rdata_nxt = word_cur;
            rresp_nxt = `APCC_RESP_OKAY;
         end else begin
            rdata_nxt = 32'h0000_0000;
            rresp_nxt = `APCC_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0000_0000;
         s_axi_rresp_o   <= `APCC_RESP_OKAY;
      end else if (ce_i) begin
         s_axi_arready_o <= arready_nxt;
         s_axi_rvalid_o  <= rvalid_nxt;
         s_axi_rdata_o   <= rdata_nxt;
         s_axi_rresp_o   <= rresp_nxt;
      end
   end

   // crystal kick
   logic kick_run;

   assign kick_run = ctrl_o.crystal_kick_enable && stop_sync_r;

   apcc_kick_timer #(
      .WIDTH_CYC  (KICK_WIDTH_CYC),
      .PERIOD_CYC (KICK_PERIOD_CYC)
   ) u_kick (
      .sys_clk_i (sys_clk_i),
      .resetn_i  (resetn_i),
      .ce_i      (ce_i),
      .run_i     (kick_run),
      .pulse_o   (crystal_kick_o)
   );

   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i || !ce_i);

   logic no_mode;
   logic [31:0] kick_hi_cnt_r;

   assign no_mode = !sleep_mode_i && !cur_detect_mode_i && !soft_reset_i;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         kick_hi_cnt_r <= 32'h0000_0000;
      end else if (ce_i) begin
         kick_hi_cnt_r <= crystal_kick_o ? kick_hi_cnt_r + 32'h0000_0001 : 32'h0000_0000;
      end
   end

   sequence s_write_b3(int unsigned bitpos);
      wr_go && wr_hit && w_strb_r[3] && w_data_r[bitpos] && no_mode;
   endsequence

   sequence s_write_b2;
      wr_go && wr_hit && w_strb_r[2] && no_mode;
   endsequence

   a_meas_adc_on: assert property (s_write_b3(`APCC_BIT_MEAS_ADC) |=> ctrl_o.meas_adc_enable)
      else $error("measurement adc enable not set by write");
   a_cur_adc_on: assert property (s_write_b3(`APCC_BIT_CUR_ADC) |=> ctrl_o.cur_adc_enable)
      else $error("current adc enable not set by write");
   a_bandgap_on: assert property (s_write_b3(`APCC_BIT_BANDGAP) |=> ctrl_o.bandgap_enable)
      else $error("bandgap enable not set by write");
   a_osc_pd_write: assert property (s_write_b2 |=> ctrl_o.crystal_osc_shutdown == $past(w_data_r[`APCC_BIT_OSC_PD]))
      else $error("oscillator shutdown bit does not follow write");
   a_clk_sel_write: assert property (s_write_b2
         |=> ctrl_o.adc_clock_select == $past(w_data_r[`APCC_BIT_CSEL_HI:`APCC_BIT_CSEL_LO]))
      else $error("adc clock select does not follow write");
   a_sleep_forces: assert property (sleep_mode_i |=> !ctrl_o.meas_adc_enable && !ctrl_o.cur_adc_enable
         && ctrl_o.crystal_osc_shutdown)
      else $error("sleep mode forced values missing");
   a_detect_forces: assert property (cur_detect_mode_i && !sleep_mode_i |=> !ctrl_o.meas_adc_enable
         && ctrl_o.cur_adc_enable && ctrl_o.crystal_osc_shutdown)
      else $error("current detection forced values missing");
   a_soft_reset: assert property (soft_reset_i && !sleep_mode_i && !cur_detect_mode_i
         |=> apcc_to_word(ctrl_o) == `APCC_CTRL0_RESET)
      else $error("soft reset did not restore defaults");
   a_kick_needs_run: assert property (crystal_kick_o |-> $past(kick_run))
      else $error("kick pulse without enable and stopped crystal");
   a_kick_width: assert property (kick_hi_cnt_r <= KICK_WIDTH_CYC)
      else $error("kick pulse longer than its width");

endmodule : apcc_top

// *** apcc_defines.svh ***
// offsets, field positions, reset values and timing counts of the analog power and clock control word
`ifndef APCC_DEFINES_SVH
`define APCC_DEFINES_SVH

`define APCC_AXI_AW          14
`define APCC_CTRL0_IDX       12'h185
`define APCC_CTRL0_ADDR      {`APCC_CTRL0_IDX, 2'b00}

`define APCC_BIT_BANDGAP     27
`define APCC_BIT_MEAS_ADC    25
`define APCC_BIT_CUR_ADC     24
`define APCC_BIT_RSVD_HI     23
`define APCC_BIT_RSVD_LO     22
`define APCC_BIT_KICK        21
`define APCC_BIT_OSC_PD      20
`define APCC_BIT_DIV_BYP     19
`define APCC_BIT_LOW_DRV     18
`define APCC_BIT_CSEL_HI     17
`define APCC_BIT_CSEL_LO     16

`define APCC_CTRL0_RESET     32'h0000_0000

`define APCC_RESP_OKAY       2'h0
`define APCC_RESP_SLVERR     2'h2

`define APCC_CLK_PERIOD_NS   25
`define APCC_KICK_WIDTH_NS   1000000
`define APCC_KICK_PERIOD_NS  1000000000
`define APCC_KICK_WIDTH_CYC  (`APCC_KICK_WIDTH_NS / `APCC_CLK_PERIOD_NS)
`define APCC_KICK_PERIOD_CYC (`APCC_KICK_PERIOD_NS / `APCC_CLK_PERIOD_NS)

`endif

// *** apcc_pkg.sv ***
// types of the analog power and clock control block
package apcc_pkg;

   typedef struct packed {
      logic       bandgap_enable;
      logic       meas_adc_enable;
      logic       cur_adc_enable;
      logic [1:0] reserved;
      logic       crystal_kick_enable;
      logic       crystal_osc_shutdown;
      logic       crystal_divider_bypass;
      logic       crystal_low_drive;
      logic [1:0] adc_clock_select;
   } apcc_ctrl_t;

endpackage : apcc_pkg

// *** apcc_kick_timer.sv ***
// periodic crystal kick pulse generator
module apcc_kick_timer #(
   parameter int unsigned WIDTH_CYC  = 40000,
   parameter int unsigned PERIOD_CYC = 40000000
) (
   input  wire logic sys_clk_i,
   input  wire logic resetn_i,
   input  wire logic ce_i,
   input  wire logic run_i,
   output logic      pulse_o
);

   localparam int CW = $clog2(PERIOD_CYC + 1);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          pulse_nxt;

   // restarting at zero makes the first pulse start right after the oscillator is seen stopped
   always_comb begin
      if (!run_i) begin
         cnt_nxt = '0;
      end else if (cnt_r == CW'(PERIOD_CYC - 1)) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + CW'(1);
      end
      pulse_nxt = run_i && (cnt_r < CW'(WIDTH_CYC));
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         cnt_r   <= '0;
         pulse_o <= 1'b0;
      end else if (ce_i) begin
         cnt_r   <= cnt_nxt;
         pulse_o <= pulse_nxt;
      end
   end

endmodule : apcc_kick_timer

// *** analog_power_clock_control_reg_tb_top.sv ***
// self-checking testbench of the analog power and clock control register
`include "apcc_defines.svh"
module analog_power_clock_control_reg_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W_CYC = 4;
   localparam int P_CYC = 20;
   localparam logic [13:0] ADDR = `APCC_CTRL0_ADDR;
   logic                    sys_clk_i = 1'b0;
   logic                    resetn_i = 1'b0;
   logic                    ce_i = 1'b1;
   logic                    soft_reset_i = 1'b0;
   logic                    sleep_mode_i = 1'b0;
   logic                    cur_detect_mode_i = 1'b0;
   logic                    crystal_stopped_i = 1'b0;
   apcc_pkg::apcc_ctrl_t    ctrl_o;
   logic                    crystal_kick_o;
   logic [13:0]             s_axi_awaddr_i = '0;
   logic                    s_axi_awvalid_i = 1'b0;
   logic                    s_axi_awready_o;
   logic [31:0]             s_axi_wdata_i = '0;
   logic [3:0]              s_axi_wstrb_i = '0;
   logic                    s_axi_wvalid_i = 1'b0;
   logic                    s_axi_wready_o;
   logic [1:0]              s_axi_bresp_o;
   logic                    s_axi_bvalid_o;
   logic                    s_axi_bready_i = 1'b0;
   logic [13:0]             s_axi_araddr_i = '0;
   logic                    s_axi_arvalid_i = 1'b0;
   logic                    s_axi_arready_o;
   logic [31:0]             s_axi_rdata_o;
   logic [1:0]              s_axi_rresp_o;
   logic                    s_axi_rvalid_o;
   logic                    s_axi_rready_i = 1'b0;
   int                      error_cnt = 0;
   int                      num_checks = 0;
   int                      cyc = 0;
   int                      seed = 32'h60858eda;
   int                      hi;
   int                      per;
   logic [31:0]             model = '0;
   logic [31:0]             rd;
   logic [1:0]              rsp;

   always #12.5 sys_clk_i = ~sys_clk_i;

   // short kick counts keep the pulse train within a few dozen cycles
   apcc_top #(.KICK_WIDTH_CYC(W_CYC), .KICK_PERIOD_CYC(P_CYC)) apcc_top_inst (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .soft_reset_i(soft_reset_i),
      .sleep_mode_i(sleep_mode_i), .cur_detect_mode_i(cur_detect_mode_i),
      .crystal_stopped_i(crystal_stopped_i), .ctrl_o(ctrl_o), .crystal_kick_o(crystal_kick_o),
      .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
      .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
      .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
      .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
      .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
      .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i));

   function automatic logic [31:0] wr_model(logic [31:0] old, logic [31:0] d, logic [3:0] s);
      logic [31:0] m;
      for (int i = 0; i < 4; i++) begin
         m[i*8+:8] = s[i] ? d[i*8+:8] : old[i*8+:8];
      end
      return m & 32'h0bff_0000;
   endfunction : wr_model

   function automatic logic [31:0] mode_model(logic [31:0] w, logic sl, logic cd);
      if (sl) begin
         w[27] = 1'b0;
         w[25] = 1'b0;
         w[24] = 1'b0;
         w[20] = 1'b1;
      end else if (cd) begin
         w[27] = 1'b1;
         w[25] = 1'b0;
         w[24] = 1'b1;
         w[20] = 1'b1;
      end
      return w;
   endfunction : mode_model

   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_val

   task automatic chk_ctrl(input apcc_pkg::apcc_ctrl_t got, input logic [31:0] w);
      num_checks++;
      if (got !== apcc_pkg::apcc_ctrl_t'({w[27], w[25:16]})) begin
         error_cnt++;
         $display("Error at %0t: ctrl_o %h for word %h", $time, got, w);
      end
   endtask : chk_ctrl

   task automatic axi_write(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      bit aw_ok;
      bit w_ok;
      bit b_ok;
      aw_ok = 0;
      w_ok = 0;
      b_ok = 0;
      s_axi_awaddr_i <= a;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wdata_i <= d;
      s_axi_wstrb_i <= s;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      while (!b_ok) begin
         @(posedge sys_clk_i);
         if (!aw_ok && s_axi_awready_o === 1'b1) begin
            aw_ok = 1;
            s_axi_awvalid_i <= 1'b0;
         end
         if (!w_ok && s_axi_wready_o === 1'b1) begin
            w_ok = 1;
            s_axi_wvalid_i <= 1'b0;
         end
         if (s_axi_bvalid_o === 1'b1) begin
            b_ok = 1;
            r = s_axi_bresp_o;
            s_axi_bready_i <= 1'b0;
         end
      end
      @(posedge sys_clk_i);
   endtask : axi_write

   task automatic axi_read(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ar_ok;
      bit r_ok;
      ar_ok = 0;
      r_ok = 0;
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      while (!r_ok) begin
         @(posedge sys_clk_i);
         if (!ar_ok && s_axi_arready_o === 1'b1) begin
            ar_ok = 1;
            s_axi_arvalid_i <= 1'b0;
         end
         if (s_axi_rvalid_o === 1'b1) begin
            r_ok = 1;
            d = s_axi_rdata_o;
            r = s_axi_rresp_o;
            s_axi_rready_i <= 1'b0;
         end
      end
      @(posedge sys_clk_i);
   endtask : axi_read

   // model follows the mode pins as they stand while the write completes
   task automatic do_write(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
      axi_write(a, d, s, rsp);
      if (a == ADDR) begin
         model = mode_model(wr_model(model, d, s), sleep_mode_i, cur_detect_mode_i);
         chk_val({30'h0, rsp}, {30'h0, `APCC_RESP_OKAY}, "bresp");
      end else begin
         chk_val({30'h0, rsp}, {30'h0, `APCC_RESP_SLVERR}, "bresp unmapped");
      end
   endtask : do_write

   task automatic check_state();
      axi_read(ADDR, rd, rsp);
      chk_val(rd, model, "readback");
      chk_val({30'h0, rsp}, {30'h0, `APCC_RESP_OKAY}, "rresp");
      chk_ctrl(ctrl_o, model);
   endtask : check_state

   task automatic count_high(output int h);
      h = 0;
      repeat (2 * P_CYC) begin
         @(posedge sys_clk_i);
         h += (crystal_kick_o !== 1'b0);
      end
   endtask : count_high

   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         $display("Error at %0t: run did not finish", $time);
         final_report();
      end
   end

   initial begin
      repeat (12) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      @(posedge sys_clk_i);
      check_state();
      for (int i = 0; i < 12; i++) begin
         do_write(ADDR, $random(seed) & 32'hfb3f_ffff, (i < 6) ? 4'hf : 4'($random(seed)));
         check_state();
      end
      for (int c = 0; c < 4; c++) begin
         do_write(ADDR, {14'h0, 2'(c), 16'h0}, 4'h4);
         check_state();
      end
      do_write(ADDR, 32'h080c_0000, 4'hf);
      check_state();
      do_write(14'h0610, 32'hffff_ffff, 4'hf);
      axi_read(14'h0618, rd, rsp);
      chk_val(rd, 32'h0, "unmapped data");
      chk_val({30'h0, rsp}, {30'h0, `APCC_RESP_SLVERR}, "unmapped rresp");
      check_state();
      // a soft reset while the clock enable is low must leave the word untouched
      ce_i <= 1'b0;
      soft_reset_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      soft_reset_i <= 1'b0;
      @(posedge sys_clk_i);
      ce_i <= 1'b1;
      check_state();
      // second hardware reset in mid-run restores defaults
      resetn_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      model = '0;
      @(posedge sys_clk_i);
      check_state();
      for (int m = 1; m < 4; m++) begin
         do_write(ADDR, 32'h0b3f_0000, 4'hf);
         sleep_mode_i <= m[0];
         cur_detect_mode_i <= m[1];
         repeat (2) @(posedge sys_clk_i);
         model = mode_model(model, m[0], m[1]);
         chk_ctrl(ctrl_o, model);
         do_write(ADDR, 32'h0b3e_0000, 4'hf);
         check_state();
         sleep_mode_i <= 1'b0;
         cur_detect_mode_i <= 1'b0;
         @(posedge sys_clk_i);
         check_state();
      end
      soft_reset_i <= 1'b1;
      @(posedge sys_clk_i);
      soft_reset_i <= 1'b0;
      model = '0;
      @(posedge sys_clk_i);
      check_state();
      do_write(ADDR, 32'h0b20_0000, 4'hf);
      check_state();
      crystal_stopped_i <= 1'b1;
      hi = 0;
      while (crystal_kick_o !== 1'b1 && hi < 100) begin
         @(posedge sys_clk_i);
         hi++;
      end
      hi = 0;
      while (crystal_kick_o === 1'b1 && hi < 100) begin
         @(posedge sys_clk_i);
         hi++;
      end
      per = hi;
      while (crystal_kick_o !== 1'b1 && per < 100) begin
         @(posedge sys_clk_i);
         per++;
      end
      chk_val(32'(hi), 32'(W_CYC), "kick width");
      chk_val(32'(per), 32'(P_CYC), "kick period");
      crystal_stopped_i <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      count_high(hi);
      chk_val(32'(hi), 32'h0, "kick with crystal running");
      crystal_stopped_i <= 1'b1;
      do_write(ADDR, 32'h0b00_0000, 4'hf);
      repeat (8) @(posedge sys_clk_i);
      count_high(hi);
      chk_val(32'(hi), 32'h0, "kick while disabled");
      final_report();
   end

endmodule : analog_power_clock_control_reg_tb_top
